// ==== inc/asram_pkg.sv ====
package asram_pkg;

	// ==========================================================================
	// Geometry
	localparam int ASRAM_ADDR_W = 16;
	localparam int ASRAM_DATA_W = 16;
	localparam int ASRAM_BYTE_W = 8;

	// ==========================================================================
	// Timing, fastest grade, in picoseconds
	localparam int ASRAM_CLK_PS        = 20000;
	localparam int ASRAM_READ_CYCLE_PS = 10000;
	localparam int ASRAM_WRITE_CYC_PS  = 10000;
	localparam int ASRAM_ACCESS_PS     = 10000;
	localparam int ASRAM_WP_PS         = 7000;
	localparam int ASRAM_DW_PS         = 5000;
	localparam int ASRAM_WHZ_PS        = 5000;
	localparam int ASRAM_OHZ_PS        = 5000;

	// Least times round up to whole cycles, never below one.
	function automatic int asram_cyc(input int ps);
		int c;
		c = (ps + ASRAM_CLK_PS - 1) / ASRAM_CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction : asram_cyc

	localparam int ASRAM_ACCESS_CYC = asram_cyc(ASRAM_ACCESS_PS);
	localparam int ASRAM_WP_CYC     = asram_cyc(ASRAM_WHZ_PS + ASRAM_DW_PS);
	localparam int ASRAM_WP_MIN_CYC = asram_cyc(ASRAM_WP_PS);
	localparam int ASRAM_RC_CYC     = asram_cyc(ASRAM_READ_CYCLE_PS);
	localparam int ASRAM_WC_CYC     = asram_cyc(ASRAM_WRITE_CYC_PS);
	localparam int ASRAM_TURN_CYC   = asram_cyc(ASRAM_OHZ_PS);
	localparam int ASRAM_CNT_W      = 4;

	localparam logic [3:0] ASRAM_CNT_ONE = 4'h1;
	localparam logic [3:0] ASRAM_CNT_ZERO = 4'h0;

	typedef enum logic [2:0] {
		ASRAM_IDLE,
		ASRAM_RD_ACC,
		ASRAM_WR_SETUP,
		ASRAM_WR_PULSE,
		ASRAM_WR_END,
		ASRAM_TURN
	} asram_state_e;

endpackage : asram_pkg

// ==== verilog/asram_timer.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Down counter that flags when the loaded wait has run out.
module asram_timer #(
	parameter int W = 4
) (
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	input  wire logic         clk_en,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              done
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} asram_tmr_s;

	asram_tmr_s st_reg;
	asram_tmr_s st_next;

	initial begin
		if (W < 2) $error("asram_timer: W must be at least 2");
	end

	always_comb begin
		st_next = st_reg;
		if (load) begin
			st_next.cnt = load_val;
		end else if (st_reg.cnt != '0) begin
			st_next.cnt = st_reg.cnt - {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	// Done ignores load on purpose: the sequencer loads on done, and a path back would
	// close a combinational loop that never settles.
	assign done = (st_reg.cnt == '0);
endmodule : asram_timer

// ==== verilog/asram_host.sv ====
`timescale 1ns/1ps
module asram_host
	import asram_pkg::*;
#(
	parameter int ADDR_W = asram_pkg::ASRAM_ADDR_W,
	parameter int DATA_W = asram_pkg::ASRAM_DATA_W
) (
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	input  wire logic              clk_en,
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	input  wire logic [1:0]        req_lane_n,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_rdata,
	output logic [ADDR_W-1:0]      word_address,
	output logic                   chip_select_n,
	output logic                   write_strobe_n,
	output logic                   output_drive_n,
	output logic                   upper_lane_enable_n,
	output logic                   lower_lane_enable_n,
	input  wire logic [DATA_W-1:0] shared_data_bus_i,
	output logic [DATA_W-1:0]      shared_data_bus_o,
	output logic                   shared_data_bus_oe
);
	import asram_pkg::*;

	// ==========================================================================
	// Elaboration checks
	initial begin
		if (DATA_W != 2 * ASRAM_BYTE_W) $error("asram_host: DATA_W must be two byte lanes");
		if (ADDR_W < 1) $error("asram_host: ADDR_W must be positive");
	end

	// ==========================================================================
	// State
	typedef struct packed {
		asram_state_e          fsm;
		logic                  ready;
		logic                  rsp_valid;
		logic [DATA_W-1:0]     rdata;
		logic [ADDR_W-1:0]     addr;
		logic                  cs_n;
		logic                  we_n;
		logic                  oe_n;
		logic                  ub_n;
		logic                  lb_n;
		logic [DATA_W-1:0]     dout;
		logic                  doe;
	} asram_host_s;

	asram_host_s st_reg;
	asram_host_s st_next;

	logic                   tmr_load;
	logic [ASRAM_CNT_W-1:0] tmr_val;
	logic                   tmr_done;

	asram_timer #(
		.W(ASRAM_CNT_W)
	) u_timer (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.clk_en  (clk_en),
		.load    (tmr_load),
		.load_val(tmr_val),
		.done    (tmr_done)
	);

	// Largest of the write-side waits; output drive stays high in writes, but the
	// longer pulse is kept so a bus left enabled by a board still works.
	localparam int WP_USE = (ASRAM_WP_CYC > ASRAM_WP_MIN_CYC) ? ASRAM_WP_CYC : ASRAM_WP_MIN_CYC;
	localparam logic [ASRAM_CNT_W-1:0] WP_LOAD   = ASRAM_CNT_W'(WP_USE - 1);
	localparam logic [ASRAM_CNT_W-1:0] ACC_LOAD  = ASRAM_CNT_W'(ASRAM_ACCESS_CYC);
	localparam logic [ASRAM_CNT_W-1:0] TURN_LOAD = ASRAM_CNT_W'(ASRAM_TURN_CYC - 1);
	localparam int RC_TOTAL = (ASRAM_RC_CYC > ASRAM_ACCESS_CYC) ? ASRAM_RC_CYC : ASRAM_ACCESS_CYC;

	initial begin
		if (RC_TOTAL >= (1 << ASRAM_CNT_W)) $error("asram_host: counter too narrow");
		if (ASRAM_WC_CYC > WP_USE + 2) $error("asram_host: write cycle longer than sequence");
	end

	// ==========================================================================
	// Sequencer
	always_comb begin
		st_next = st_reg;
		tmr_load = 1'b0;
		tmr_val = ASRAM_CNT_ZERO;
		st_next.rsp_valid = 1'b0;
		case (st_reg.fsm)
			ASRAM_IDLE: begin
				st_next.ready = 1'b1;
				if (st_reg.ready && req_valid) begin
					st_next.ready = 1'b0;
					// Address and lanes change on the same edge that select falls.
					st_next.addr = req_addr;
					st_next.ub_n = req_lane_n[1];
					st_next.lb_n = req_lane_n[0];
					st_next.cs_n = 1'b0;
					if (&req_lane_n) begin
						// No lane selected: nothing would move, finish at once.
						st_next.cs_n = 1'b1;
						st_next.rsp_valid = 1'b1;
						st_next.ready = 1'b1;
					end else if (req_write) begin
						// Output drive stays high so the memory never drives here.
						st_next.oe_n = 1'b1;
						st_next.dout = req_wdata;
						st_next.fsm = ASRAM_WR_SETUP;
					end else begin
						st_next.oe_n = 1'b0;
						tmr_load = 1'b1;
						tmr_val = ACC_LOAD;
						st_next.fsm = ASRAM_RD_ACC;
					end
				end
			end
			ASRAM_RD_ACC: begin
				if (tmr_done) begin
					// Sampled only once the access time has passed.
					st_next.rdata = shared_data_bus_i;
					if (st_reg.ub_n) st_next.rdata[DATA_W-1:ASRAM_BYTE_W] = '0;
					if (st_reg.lb_n) st_next.rdata[ASRAM_BYTE_W-1:0] = '0;
					st_next.rsp_valid = 1'b1;
					st_next.cs_n = 1'b1;
					st_next.oe_n = 1'b1;
					st_next.ub_n = 1'b1;
					st_next.lb_n = 1'b1;
					tmr_load = 1'b1;
					tmr_val = TURN_LOAD;
					st_next.fsm = ASRAM_TURN;
				end
			end
			ASRAM_WR_SETUP: begin
				// Strobe falls after select and lanes, bus driven with data.
				st_next.we_n = 1'b0;
				st_next.doe = 1'b1;
				tmr_load = 1'b1;
				tmr_val = WP_LOAD;
				st_next.fsm = ASRAM_WR_PULSE;
			end
			ASRAM_WR_PULSE: begin
				if (tmr_done) begin
					// Data has stood the whole pulse, well over setup.
					st_next.we_n = 1'b1;
					st_next.fsm = ASRAM_WR_END;
				end
			end
			ASRAM_WR_END: begin
				// Hold data and address one cycle past the strobe rising.
				st_next.doe = 1'b0;
				st_next.cs_n = 1'b1;
				st_next.ub_n = 1'b1;
				st_next.lb_n = 1'b1;
				st_next.rsp_valid = 1'b1;
				st_next.ready = 1'b1;
				st_next.fsm = ASRAM_IDLE;
			end
			ASRAM_TURN: begin
				// Give the memory its turn-off time before anyone drives.
				if (tmr_done) begin
					st_next.ready = 1'b1;
					st_next.fsm = ASRAM_IDLE;
				end
			end
			default: begin
				st_next.fsm = ASRAM_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '{
				fsm: ASRAM_IDLE, ready: 1'b0, rsp_valid: 1'b0, rdata: '0,
				addr: '0, cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, ub_n: 1'b1,
				lb_n: 1'b1, dout: '0, doe: 1'b0
			};
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	// ==========================================================================
	// Outputs, all straight from the state register
	assign req_ready           = st_reg.ready;
	assign rsp_valid           = st_reg.rsp_valid;
	assign rsp_rdata           = st_reg.rdata;
	assign word_address        = st_reg.addr;
	assign chip_select_n       = st_reg.cs_n;
	assign write_strobe_n      = st_reg.we_n;
	assign output_drive_n      = st_reg.oe_n;
	assign upper_lane_enable_n = st_reg.ub_n;
	assign lower_lane_enable_n = st_reg.lb_n;
	assign shared_data_bus_o   = st_reg.dout;
	assign shared_data_bus_oe  = st_reg.doe;
endmodule : asram_host

// ==== tb/asram_props.sv ====
`timescale 1ns/1ps
module asram_props (
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic        clk_en,
	input wire logic        req_valid,
	input wire logic        req_write,
	input wire logic [1:0]  req_lane_n,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	input wire logic [15:0] word_address,
	input wire logic        chip_select_n,
	input wire logic        write_strobe_n,
	input wire logic        output_drive_n,
	input wire logic        upper_lane_enable_n,
	input wire logic        lower_lane_enable_n,
	input wire logic [15:0] shared_data_bus_o,
	input wire logic        shared_data_bus_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n || !clk_en);
	sequence wr_pulse_s;
		shared_data_bus_oe ##1 write_strobe_n && $stable(shared_data_bus_o);
	endsequence
	sequence wr_close_s;
		chip_select_n && !shared_data_bus_oe && rsp_valid;
	endsequence
	// The memory drives for two cycles; the closing edge drops select and drive together.
	sequence rd_close_s;
		write_strobe_n ##2 output_drive_n && chip_select_n && rsp_valid;
	endsequence
	sequence rd_take_s;
		req_valid && req_ready && !req_write && req_lane_n != 2'h3;
	endsequence
	sequence rd_gap_s;
		!req_ready [*3] ##1 req_ready;
	endsequence
	bus_fight_a: assert property (shared_data_bus_oe |-> output_drive_n && !chip_select_n)
		else $error("host drives bus while memory may drive");
	wr_pulse_a: assert property ($fell(write_strobe_n) |-> wr_pulse_s ##1 wr_close_s)
		else $error("write pulse malformed");
	data_setup_a: assert property ($fell(write_strobe_n) |-> $stable(shared_data_bus_o))
		else $error("write data not set up");
	addr_hold_a: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(word_address))
		else $error("address moved while selected");
	lane_sel_a: assert property (!chip_select_n |-> !(upper_lane_enable_n && lower_lane_enable_n))
		else $error("select without lane");
	rd_close_a: assert property ($fell(output_drive_n) |-> rd_close_s)
		else $error("read cycle malformed");
	rd_gap_a: assert property (rd_take_s |=> rd_gap_s)
		else $error("read spacing wrong");
	strobe_sel_a: assert property (!write_strobe_n |-> !chip_select_n && output_drive_n)
		else $error("strobe outside select");
endmodule : asram_props
bind asram_host asram_props chk_u (.ref_clk, .arst_n, .clk_en, .req_valid, .req_write,
	.req_lane_n, .req_ready, .rsp_valid, .word_address, .chip_select_n, .write_strobe_n,
	.output_drive_n, .upper_lane_enable_n, .lower_lane_enable_n, .shared_data_bus_o,
	.shared_data_bus_oe);

// ==== tb/asram_mem_model.sv ====
`timescale 1ns/1ps
module asram_mem_model (
	input wire logic [15:0] word_address,
	input wire logic        chip_select_n,
	input wire logic        write_strobe_n,
	input wire logic        output_drive_n,
	input wire logic        upper_lane_enable_n,
	input wire logic        lower_lane_enable_n,
	input wire logic [15:0] mem_din,
	output logic [15:0]     mem_dout,
	output logic [1:0]      lane_drive
);
	logic [15:0] mem [65536];
	logic        wr;
	logic        rd;
	// No clock here: every action follows the address, data and control pins alone.
	assign wr = !chip_select_n && !write_strobe_n;
	assign rd = !chip_select_n && !output_drive_n && write_strobe_n;
	assign lane_drive = {rd && !upper_lane_enable_n, rd && !lower_lane_enable_n};
	always @* begin
		if (wr && !lower_lane_enable_n) mem[word_address][7:0] = mem_din[7:0];
		if (wr && !upper_lane_enable_n) mem[word_address][15:8] = mem_din[15:8];
	end
	// Unknown until the access time runs out, so a hasty sample is caught.
	always @(word_address or rd or upper_lane_enable_n or lower_lane_enable_n) begin
		mem_dout = 16'hXXXX;
		mem_dout <= #10 mem[word_address];
	end
endmodule : asram_mem_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [15:0] req_addr = 16'h0000;
	logic [15:0] req_wdata = 16'h0000;
	logic [1:0] req_lane_n = 2'h3;
	logic req_ready, rsp_valid, chip_select_n, write_strobe_n, output_drive_n;
	logic upper_lane_enable_n, lower_lane_enable_n, shared_data_bus_oe;
	logic [15:0] rsp_rdata, word_address, shared_data_bus_o, bus, mem_dout;
	logic [15:0] fl = 16'h5AA5;
	logic [1:0] lane_drive;
	int n_fail = 0;
	int checks_done = 0;
	always #10 ref_clk = ~ref_clk;
	// A released lane shows a changing pattern, never the last driven value.
	always @(posedge ref_clk) fl <= ~fl;
	assign bus = shared_data_bus_oe ? shared_data_bus_o :
		{lane_drive[1] ? mem_dout[15:8] : fl[15:8], lane_drive[0] ? mem_dout[7:0] : fl[7:0]};
	asram_host dut_u (.ref_clk, .arst_n, .clk_en, .req_valid, .req_write, .req_addr, .req_wdata,
		.req_lane_n, .req_ready, .rsp_valid, .rsp_rdata, .word_address, .chip_select_n,
		.write_strobe_n, .output_drive_n, .upper_lane_enable_n, .lower_lane_enable_n,
		.shared_data_bus_i(bus), .shared_data_bus_o, .shared_data_bus_oe);
	asram_mem_model mem_u (.word_address, .chip_select_n, .write_strobe_n, .output_drive_n,
		.upper_lane_enable_n, .lower_lane_enable_n, .mem_din(bus), .mem_dout, .lane_drive);
	// ==========================================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Values read just after an edge are those the design sampled at it.
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
		input logic [1:0] l, input int lat, input logic [15:0] e, input string nm);
		int n;
		n = 0;
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		req_lane_n <= l;
		do begin @(posedge ref_clk); n++; end while (req_ready !== 1'b1 && n < 20);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
			if (l == 2'h3) chk("idle select", 16'h0001, {15'h0000, chip_select_n});
		end while (rsp_valid !== 1'b1 && n < 20);
		chk({nm, " latency"}, 16'(lat + 1), 16'(n));
		if (!w) chk(nm, e, rsp_rdata);
	endtask : xfer
	task automatic end_sim();
		if (n_fail == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim
	// ==========================================================================
	// Scenarios
	task automatic s_word();
		xfer(1'b1, 16'h0000, 16'hA5C3, 2'h0, 3, 16'h0000, "wr lo");
		xfer(1'b1, 16'hFFFF, 16'h3C5A, 2'h0, 3, 16'h0000, "wr hi");
		xfer(1'b0, 16'h0000, 16'h0000, 2'h0, 2, 16'hA5C3, "rd lo");
		xfer(1'b0, 16'hFFFF, 16'h0000, 2'h0, 2, 16'h3C5A, "rd hi");
	endtask : s_word
	task automatic s_lane();
		xfer(1'b1, 16'hFFFF, 16'h77AB, 2'h2, 3, 16'h0000, "wr low lane");
		xfer(1'b1, 16'hFFFF, 16'hCD11, 2'h1, 3, 16'h0000, "wr up lane");
		xfer(1'b0, 16'hFFFF, 16'h0000, 2'h2, 2, 16'h00AB, "rd low lane");
		xfer(1'b0, 16'hFFFF, 16'h0000, 2'h1, 2, 16'hCD00, "rd up lane");
		xfer(1'b0, 16'hFFFF, 16'h0000, 2'h0, 2, 16'hCDAB, "rd merged");
	endtask : s_lane
	task automatic s_nolane();
		xfer(1'b1, 16'h0000, 16'hFFFF, 2'h3, 0, 16'h0000, "no lane wr");
		xfer(1'b0, 16'h0000, 16'h0000, 2'h0, 2, 16'hA5C3, "kept word");
	endtask : s_nolane
	// A read frozen by the clock enable for three edges must resume where it stopped.
	task automatic s_hold();
		int n;
		n = 0;
		req_valid <= 1'b1;
		req_write <= 1'b0;
		req_addr <= 16'hFFFF;
		req_lane_n <= 2'h0;
		do begin @(posedge ref_clk); n++; end while (req_ready !== 1'b1 && n < 20);
		req_valid <= 1'b0;
		clk_en <= 1'b0;
		repeat (3) begin
			@(posedge ref_clk);
			chk("frozen pins", 16'h0000, {14'h0000, chip_select_n, rsp_valid});
		end
		clk_en <= 1'b1;
		n = 0;
		do begin @(posedge ref_clk); n++; end while (rsp_valid !== 1'b1 && n < 20);
		chk("frozen latency", 16'h0003, 16'(n));
		chk("frozen read", 16'hCDAB, rsp_rdata);
	endtask : s_hold
	initial begin
		repeat (5) @(posedge ref_clk);
		chk("reset pins", 16'h003E, {10'h000, chip_select_n, write_strobe_n, output_drive_n,
			upper_lane_enable_n, lower_lane_enable_n, shared_data_bus_oe});
		arst_n <= 1'b1;
		s_word();
		s_lane();
		s_nolane();
		s_hold();
		end_sim();
	end
	initial begin
		#100000;
		n_fail++;
		end_sim();
	end
endmodule : tb
